//--- bsns_pkg.sv
// Package for the borrow-subtract and nibble-swap execution datapath.
// Assumes a core that supplies decoded instruction words and a data-memory port.
package bsns_pkg;

  // ****************************************************************
  // Opcode fields
  // ****************************************************************
  localparam logic [5:0] OPC_SUB_BORROW = 6'h16;
  localparam logic [5:0] OPC_NIBBLE_SWP = 6'h0E;
  localparam int         OPC_MSB        = 15;
  localparam int         OPC_LSB        = 10;
  localparam int         DEST_BIT       = 9;
  localparam int         ACCESS_BIT     = 8;

  // ****************************************************************
  // Addressing constants
  // ****************************************************************
  localparam logic [7:0] INDEXED_LIMIT  = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0] SFR_BANK       = 4'hF;

  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int STAT_C  = 0;
  localparam int STAT_DC = 1;
  localparam int STAT_Z  = 2;
  localparam int STAT_OV = 3;
  localparam int STAT_N  = 4;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [7:0] WREG_RESET   = 8'h00;

  // Quarter phases of one instruction cycle, Gray coded.
  typedef enum logic [1:0] {
    Q_DECODE  = 2'b00,
    Q_READ    = 2'b01,
    Q_PROCESS = 2'b11,
    Q_WRITE   = 2'b10
  } bsns_phase_e;

endpackage : bsns_pkg

//--- bsns_alu_if.sv
// Interface carrying operands and results between the sequencer and the ALU.
// Assumes both ends share the core clock.
`timescale 1ns/1ns
interface bsns_alu_if;
  logic       is_swap;
  logic [7:0] file_val;
  logic [7:0] wreg_val;
  logic [4:0] status_in;
  logic [7:0] result;
  logic [4:0] status_out;
  modport seq (output is_swap, output file_val, output wreg_val, output status_in,
               input result, input status_out);
  modport alu (input is_swap, input file_val, input wreg_val, input status_in,
               output result, output status_out);
endinterface : bsns_alu_if

//--- bsns_alu.sv
// Combinational arithmetic for subtract-with-borrow and nibble swap.
// Assumes operands stable through the process phase.
`timescale 1ns/1ns
module bsns_alu (
  // Operand and result bundle
  bsns_alu_if.alu a
);

  logic [8:0] diff;
  logic [4:0] low_diff;
  logic       borrow;

  always_comb begin
    borrow   = ~a.status_in[bsns_pkg::STAT_C];
    diff     = {1'b0, a.file_val} - {1'b0, a.wreg_val} - {8'h00, borrow};
    low_diff = {1'b0, a.file_val[3:0]} - {1'b0, a.wreg_val[3:0]} - {4'h0, borrow};
    a.status_out = a.status_in;
    if (a.is_swap) begin
      a.result = {a.file_val[3:0], a.file_val[7:4]};
    end else begin
      a.result = diff[7:0];
      a.status_out[bsns_pkg::STAT_C]  = ~diff[8];
      a.status_out[bsns_pkg::STAT_DC] = ~low_diff[4];
      a.status_out[bsns_pkg::STAT_Z]  = (diff[7:0] == 8'h00);
      a.status_out[bsns_pkg::STAT_N]  = diff[7];
      a.status_out[bsns_pkg::STAT_OV] = (a.file_val[7] != a.wreg_val[7]) &&
                                        (diff[7] != a.file_val[7]);
    end
  end

endmodule : bsns_alu

//--- bsns_core.sv
// Execution datapath top: sequences one instruction per four quarter phases.
// Assumes data memory answers a read within the same phase (combinational read data).
`timescale 1ns/1ns

// Operation
// - Subtract-with-borrow gives file operand minus working register minus inverted carry.
// - Destination bit 0 writes the working register, 1 writes back to the file register.
// - Access bit 0 selects the access bank, 1 uses the bank select register.
// - Extended mode with access bit 0 uses indexed literal offset for addresses up to 5Fh.
// - A negative result sets N and clears Z; C is cleared only when the subtraction borrows.
// - Nibble swap exchanges operand nibbles and leaves all flags unchanged.
module bsns_core (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  // Instruction issue
  input  wire logic [15:0] INSTR,
  input  wire logic        INSTR_VALID,
  output logic             INSTR_READY,
  // Mode and bank state
  input  wire logic        EXT_MODE,
  input  wire logic [3:0]  BANK_SELECT_REGISTER,
  input  wire logic [7:0]  INDEX_BASE,
  // Data memory port
  output logic [11:0]      MEM_ADDR,
  input  wire logic [7:0]  MEM_RDATA,
  output logic [7:0]       MEM_WDATA,
  output logic             MEM_RD,
  output logic             MEM_WR,
  // Architectural state
  output logic [7:0]       WREG,
  output logic [4:0]       STATUS,
  output logic             DONE
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic acc,
                                           input logic ext, input logic [3:0] bank,
                                           input logic [7:0] base);
    logic [11:0] sum;
    sum = {4'h0, base} + {4'h0, f};
    if (acc) begin
      eff_addr = {bank, f};
    end else if (ext && (f <= bsns_pkg::INDEXED_LIMIT)) begin
      eff_addr = sum;
    end else if (f < bsns_pkg::ACCESS_SPLIT) begin
      eff_addr = {4'h0, f};
    end else begin
      eff_addr = {bsns_pkg::SFR_BANK, f};
    end
  endfunction : eff_addr

  // ****************************************************************
  // Phase sequencer and latched instruction
  // ****************************************************************
  bsns_pkg::bsns_phase_e phase;
  bsns_pkg::bsns_phase_e next_phase;
  logic        busy;
  logic        next_busy;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic [11:0] addr;
  logic [11:0] next_addr;
  logic [7:0]  opnd;
  logic [7:0]  next_opnd;
  logic [7:0]  res;
  logic [7:0]  next_res;
  logic [4:0]  stat_new;
  logic [4:0]  next_stat_new;
  logic [7:0]  next_wreg;
  logic [4:0]  next_status;
  logic        next_done;
  logic        is_swap;
  logic        dest_file;

  bsns_alu_if alu_bus ();
  bsns_alu u_alu (.a(alu_bus.alu));

  assign is_swap   = (ir[bsns_pkg::OPC_MSB:bsns_pkg::OPC_LSB] == bsns_pkg::OPC_NIBBLE_SWP);
  assign dest_file = ir[bsns_pkg::DEST_BIT];

  assign alu_bus.is_swap   = is_swap;
  assign alu_bus.file_val  = opnd;
  assign alu_bus.wreg_val  = WREG;
  assign alu_bus.status_in = STATUS;

  // Ready stays low until the internal reset copy is released, so no issue is offered and lost.
  assign INSTR_READY = rst_n && (phase == bsns_pkg::Q_DECODE) && !busy;
  assign MEM_ADDR    = addr;
  assign MEM_WDATA   = res;
  assign MEM_RD      = busy && (phase == bsns_pkg::Q_READ);
  assign MEM_WR      = busy && (phase == bsns_pkg::Q_WRITE) && dest_file;

  always_comb begin
    next_phase    = phase;
    next_busy     = busy;
    next_ir       = ir;
    next_addr     = addr;
    next_opnd     = opnd;
    next_res      = res;
    next_stat_new = stat_new;
    next_wreg     = WREG;
    next_status   = STATUS;
    next_done     = 1'b0;
    unique case (phase)
      bsns_pkg::Q_DECODE: begin
        if (busy || INSTR_VALID) begin
          if (!busy) begin
            next_ir   = INSTR;
            next_addr = eff_addr(INSTR[7:0], INSTR[bsns_pkg::ACCESS_BIT], EXT_MODE,
                                 BANK_SELECT_REGISTER, INDEX_BASE);
          end
          next_busy  = 1'b1;
          next_phase = bsns_pkg::Q_READ;
        end
      end
      bsns_pkg::Q_READ: begin
        next_opnd  = MEM_RDATA;
        next_phase = bsns_pkg::Q_PROCESS;
      end
      bsns_pkg::Q_PROCESS: begin
        next_res      = alu_bus.result;
        next_stat_new = alu_bus.status_out;
        next_phase    = bsns_pkg::Q_WRITE;
      end
      bsns_pkg::Q_WRITE: begin
        if (!dest_file) begin
          next_wreg = res;
        end
        next_status = stat_new;
        next_done   = 1'b1;
        next_busy   = 1'b0;
        next_phase  = bsns_pkg::Q_DECODE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase    <= bsns_pkg::Q_DECODE;
      busy     <= 1'b0;
      ir       <= 16'h0000;
      addr     <= 12'h000;
      opnd     <= 8'h00;
      res      <= 8'h00;
      stat_new <= bsns_pkg::STATUS_RESET;
      WREG     <= bsns_pkg::WREG_RESET;
      STATUS   <= bsns_pkg::STATUS_RESET;
      DONE     <= 1'b0;
    end else begin
      phase    <= next_phase;
      busy     <= next_busy;
      ir       <= next_ir;
      addr     <= next_addr;
      opnd     <= next_opnd;
      res      <= next_res;
      stat_new <= next_stat_new;
      WREG     <= next_wreg;
      STATUS   <= next_status;
      DONE     <= next_done;
    end
  end

endmodule : bsns_core

//--- bsns_chk.sv
// Assertion checker for the borrow-subtract and nibble-swap datapath.
// Assumes it is bound to the datapath top and sees only its ports.
`timescale 1ns/1ns
module bsns_chk (
  input wire logic        REF_CLK,
  input wire logic        ARST_N,
  input wire logic [15:0] INSTR,
  input wire logic        INSTR_VALID,
  input wire logic        INSTR_READY,
  input wire logic        EXT_MODE,
  input wire logic [3:0]  BANK_SELECT_REGISTER,
  input wire logic [7:0]  INDEX_BASE,
  input wire logic [11:0] MEM_ADDR,
  input wire logic [7:0]  MEM_RDATA,
  input wire logic [7:0]  MEM_WDATA,
  input wire logic        MEM_RD,
  input wire logic        MEM_WR,
  input wire logic [4:0]  STATUS,
  input wire logic        DONE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic tk;
  logic sw;
  assign tk = INSTR_VALID && INSTR_READY;
  assign sw = tk && INSTR[15:10] == bsns_pkg::OPC_NIBBLE_SWP;
  property p_rd; tk |=> MEM_RD && !INSTR_READY; endproperty
  a_rd: assert property (p_rd) else $error("no read phase after issue");
  property p_busy; tk |=> !INSTR_READY [*3]; endproperty
  a_busy: assert property (p_busy) else $error("ready during busy phases");
  property p_done; tk |-> ##4 DONE; endproperty
  a_done: assert property (p_done) else $error("done not four cycles after issue");
  property p_wr; tk |-> ##3 MEM_WR == $past(INSTR[9], 3); endproperty
  a_wr: assert property (p_wr) else $error("memory write does not follow d");
  property p_flag; sw |-> ##4 STATUS == $past(STATUS, 4); endproperty
  a_flag: assert property (p_flag) else $error("swap changed the flags");
  property p_swp;
    sw |-> ##3 MEM_WDATA == {$past(MEM_RDATA[3:0], 2), $past(MEM_RDATA[7:4], 2)};
  endproperty
  a_swp: assert property (p_swp) else $error("swap result wrong");
  property p_bank;
    tk && INSTR[8] |=> MEM_ADDR == {$past(BANK_SELECT_REGISTER), $past(INSTR[7:0])};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_idx;
    tk && !INSTR[8] && EXT_MODE && INSTR[7:0] <= 8'h5F
      |=> MEM_ADDR[7:0] == $past(INDEX_BASE) + $past(INSTR[7:0]);
  endproperty
  a_idx: assert property (p_idx) else $error("indexed address wrong");
endmodule : bsns_chk

bind bsns_core bsns_chk u_chk (.*);

//--- testbench.sv
// Self-checking bench for the borrow-subtract and nibble-swap datapath.
// Assumes a combinational data memory, modelled here by the bench.
`timescale 1ns/1ns
module testbench;
  localparam logic [5:0] sb = bsns_pkg::OPC_SUB_BORROW;
  localparam logic [5:0] sw = bsns_pkg::OPC_NIBBLE_SWP;
  logic        clk, arst_n, valid, ext, ready, rd, wr, done;
  logic [15:0] instr;
  logic [3:0]  bsel;
  logic [7:0]  ibase, rdata, rdat, wdata, wreg;
  logic [11:0] addr;
  logic [4:0]  status;
  int          bad_count, samples_checked;
  // Outside the read phase the memory shows the inverse of its data.
  assign rdat = rd ? rdata : ~rdata;
  bsns_core uut (
    .REF_CLK(clk), .ARST_N(arst_n), .INSTR(instr), .INSTR_VALID(valid),
    .INSTR_READY(ready), .EXT_MODE(ext), .BANK_SELECT_REGISTER(bsel),
    .INDEX_BASE(ibase), .MEM_ADDR(addr), .MEM_RDATA(rdat), .MEM_WDATA(wdata),
    .MEM_RD(rd), .MEM_WR(wr), .WREG(wreg), .STATUS(status), .DONE(done)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic [15:0] ins, input logic ex, input logic [3:0] bk,
                    input logic [7:0] rv, input logic [11:0] ea, input logic [7:0] w,
                    input logic [4:0] st, input logic [7:0] wd);
    int n;
    n = 0;
    @(negedge clk);
    instr = ins;
    ext = ex;
    bsel = bk;
    rdata = rv;
    valid = 1'b1;
    while (ready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk({11'h000, ready}, 12'h001);
    if (ready !== 1'b1) results();
    @(negedge clk);
    valid = 1'b0;
    chk(addr, ea);
    n = 0;
    while (done !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(12'(n), 12'h003);
    if (n >= 8) results();
    chk(wreg, w);
    chk(status, st);
    if (ins[9]) chk(wdata, wd);
  endtask : op
  task automatic t_neg;
    op({sw, 2'b00, 8'h70}, 1'b0, 4'h0, 8'h53, 12'hF70, 8'h35, 5'h00, 8'h00);
    op({sb, 2'b01, 8'h40}, 1'b0, 4'h3, 8'h35, 12'h340, 8'hFF, 5'h10, 8'h00);
  endtask : t_neg
  task automatic t_zero;
    op({sb, 2'b10, 8'h10}, 1'b1, 4'h0, 8'h00, 12'h030, 8'hFF, 5'h04, 8'h00);
    op({sw, 2'b00, 8'h5F}, 1'b1, 4'h0, 8'h10, 12'h07F, 8'h01, 5'h04, 8'h00);
  endtask : t_zero
  task automatic t_carry;
    op({sb, 2'b00, 8'h60}, 1'b1, 4'h0, 8'h03, 12'hF60, 8'h01, 5'h03, 8'h00);
    op({sb, 2'b10, 8'h5F}, 1'b0, 4'h0, 8'h1A, 12'h05F, 8'h01, 5'h03, 8'h19);
  endtask : t_carry
  initial begin
    arst_n = 1'b0;
    valid = 1'b0;
    instr = 16'h0000;
    ext = 1'b0;
    bsel = 4'h0;
    ibase = 8'h20;
    rdata = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    t_neg();
    t_zero();
    t_carry();
    results();
  end
endmodule : testbench
